// ===== verilog/dual_dac_interp_modulator_path.sv
// transmit datapath: input demux, interpolators, oscillator, modulator
`timescale 1ns/10ps
module dual_dac_interp_modulator_path (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic [13:0]               data_a,
  input  wire logic [13:0]               data_b,
  input  wire logic                      iq_select_strobe,
  input  wire logic                      reg_wr_en,
  input  wire logic                      reg_rd_en,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic [7:0]                     reg_rdata,
  input  wire logic                      out_ready,
  output logic                           out_valid,
  output dac_path_pkg::out_sample_t      out_sample,
  output logic                           in_ready,
  output logic                           rate_marker,
  output logic [3:0]                     gain_coarse_a,
  output logic [5:0]                     gain_fine_a,
  output logic [3:0]                     gain_coarse_b,
  output logic [5:0]                     gain_fine_b,
  output logic [1:0]                     core_clock_phase,
  output logic                           core_clock_invert,
  output logic [1:0]                     clock_div_sel
);
  import dac_path_pkg::*;

  typedef logic [54:0][15:0] line_t;

  typedef struct packed {
    logic [15:0][7:0]  regs;
    logic [7:0]        rdata;
    logic [13:0]       da1;
    logic [13:0]       da2;
    logic [13:0]       db1;
    logic [13:0]       db2;
    logic              st1;
    logic              st2;
    logic              st3;
    logic [2:0]        ph;
    logic              sel;
    logic [15:0]       hold;
    logic [1:0][15:0]  pair;
    logic [1:0][54:0][15:0] dl1;
    logic [1:0][54:0][15:0] dl2;
    logic [1:0][54:0][15:0] dl3;
    logic [1:0][54:0][15:0] dls;
    logic [1:0][15:0]  y1;
    logic [1:0][15:0]  y2;
    logic [1:0][15:0]  y3;
    logic [31:0]       acc;
    out_sample_t       outs;
    out_sample_t       skid;
    logic              out_v;
    logic              skid_v;
    logic              in_rdy;
    logic              mark;
  } state_t;

  state_t s;
  state_t n;

  // tap value by stage and position
  function automatic int coef(input int st, input int k);
    int c;
    int d;
    c = (st == 0) ? (H1_N - 1) / 2 : (st == 1) ? (H2_N - 1) / 2 :
        (st == 2) ? (H3_N - 1) / 2 : (HS_N - 1) / 2;
    d = (k > c) ? k - c : c - k;
    if (k > 2 * c) return 0;
    if (st == 3) return (d == 0) ? HS_C : HS_SIDE[d - 1];
    if (d == 0) return (st == 0) ? H1_C : (st == 1) ? H2_C : H3_C;
    if (d % 2 == 0) return 0;
    return (st == 0) ? H1_SIDE[(d - 1) / 2] :
           (st == 1) ? H2_SIDE[(d - 1) / 2] : H3_SIDE[(d - 1) / 2];
  endfunction

  // saturate to 16-bit signed
  function automatic logic [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sd32767) return 16'h7fff;
    if (v < -48'sd32768) return 16'h8000;
    return v[15:0];
  endfunction

  // saturate to 14-bit signed
  function automatic logic [13:0] sat14(input logic signed [15:0] v);
    if (v > 16'sd8191) return 14'h1fff;
    if (v < -16'sd8192) return 14'h2000;
    return v[13:0];
  endfunction

  // fir over a delay line, scaled back by the stage shift
  function automatic logic [15:0] fir(input line_t ln, input int st);
    logic signed [47:0] a;
    int k;
    int sh;
    a = '0;
    sh = (st == 0) ? H1_SHIFT : (st == 1) ? H2_SHIFT :
         (st == 2) ? H3_SHIFT : HS_SHIFT;
    for (k = 0; k < H1_N; k++) begin
      a = a + 48'(coef(st, k)) * 48'($signed(ln[k]));
    end
    return sat16(a >>> sh);
  endfunction

  // shift one sample into a delay line
  function automatic line_t push(input line_t ln, input logic [15:0] x);
    return {ln[53:0], x};
  endfunction

  // sine from six phase bits, quarter table mirrored
  function automatic logic signed [15:0] sin6(input logic [5:0] p);
    logic [3:0] i;
    int v;
    i = p[4] ? 4'(15 - int'(p[3:0])) : p[3:0];
    v = SIN_Q[i];
    return p[5] ? 16'(-v) : 16'(v);
  endfunction

  // input word to internal two's complement
  function automatic logic [15:0] to_tc(input logic [13:0] x,
                                        input logic offs);
    logic [13:0] t;
    t = {x[13] ^ offs, x[12:0]};
    return {{2{t[13]}}, t};
  endfunction

  logic              run;
  logic              il;
  logic              eight;
  logic              offs;
  logic              rise;
  logic              sel;
  logic              word_en;
  logic [2:0]        spc;
  logic              e1;
  logic              i1;
  logic              e2;
  logic [31:0]       fstep;
  logic [31:0]       pacc;
  logic signed [15:0] cs;
  logic signed [15:0] sn;
  logic [1:0][15:0]  pre;
  logic signed [31:0] ic;
  logic signed [31:0] is;
  logic signed [31:0] qc;
  logic signed [31:0] qs;
  logic signed [15:0] ma;
  logic signed [15:0] mb;
  logic [2:0]        md;
  logic [1:0]        dv;
  logic [1:0][15:0]  fin;
  out_sample_t       nw;
  logic [3:0]        ra;
  logic              mapped;

  always_comb begin
    n = s;
    // pin synchronisers, two stages before use
    n.da1 = data_a;
    n.da2 = s.da1;
    n.db1 = data_b;
    n.db2 = s.db1;
    n.st1 = iq_select_strobe;
    n.st2 = s.st1;
    n.st3 = s.st2;

    // register port at printed offsets
    ra = reg_addr[3:0];
    mapped = (reg_addr[7:4] == 4'h0) && (ra != 4'h9) && (ra != 4'hc);
    if (reg_wr_en && mapped) begin
      if (ra == REG_CLKGEN) n.regs[ra] = reg_wdata & CLKGEN_MASK;
      else if (ra == REG_DAC_CFG) n.regs[ra] = reg_wdata & DAC_CFG_MASK;
      else n.regs[ra] = reg_wdata;
    end
    if (reg_rd_en) n.rdata = mapped ? s.regs[ra] : 8'h00;

    run = !s.skid_v;
    il = s.regs[REG_COMMON][COM_PORT_MODE];
    offs = !s.regs[REG_COMMON][COM_CODING];
    eight = (s.regs[REG_TXCFG][1:0] == INTERP_8X);
    md = s.regs[REG_TXCFG][TX_MOD_LSB +: 3];
    dv = s.regs[REG_CLKGEN][CG_DIV_LSB +: 2];

    spc = (dv == DIV_2) ? 3'h1 : (dv == DIV_8) ? 3'h7 : 3'h3;
    word_en = run && ((s.ph & spc) == 3'h0);
    n.mark = word_en;

    rise = s.st2 && !s.st3;
    // next word goes to I after an edge
    sel = rise ? 1'b0 : s.sel;
    n.sel = sel;
    if (word_en) begin
      if (!il) begin
        // dual port, each channel its own input
        n.pair[0] = to_tc(s.da2, offs);
        n.pair[1] = to_tc(s.db2, offs);
      end else if (!sel) begin
        // shared port, steer into I latch
        n.hold = to_tc(s.da2, offs);
        n.sel = 1'b1;
      end else begin
        n.pair[0] = s.hold;
        n.pair[1] = to_tc(s.da2, offs);
        n.sel = 1'b0;
      end
    end

    // stage enables from the phase counter
    if (run) n.ph = s.ph + 3'h1;
    e1 = eight ? (s.ph[1:0] == 2'h0) : !s.ph[0];
    i1 = eight ? (s.ph == 3'h0) : (s.ph[1:0] == 2'h0);
    e2 = eight ? !s.ph[0] : 1'b1;
    for (int c = 0; c < 2; c++) begin
      if (run && e1) begin
        n.dl1[c] = push(s.dl1[c], i1 ? s.pair[c] : 16'h0);
        n.y1[c] = fir(n.dl1[c], 0);
      end
      if (run && e2) begin
        n.dl2[c] = push(s.dl2[c], e1 ? s.y1[c] : 16'h0);
        n.y2[c] = fir(n.dl2[c], 1);
      end
      if (run && eight) begin
        n.dl3[c] = push(s.dl3[c], e2 ? s.y2[c] : 16'h0);
        n.y3[c] = fir(n.dl3[c], 2);
      end
    end
    pre = eight ? s.y3 : s.y2;

    // full word; low-power top five bits
    fstep = s.regs[REG_TXCFG][TX_LP] ?
            {s.regs[REG_FREQ3][7:3], 27'h0} :
            {s.regs[REG_FREQ3], s.regs[REG_FREQ2], s.regs[REG_FREQ1],
             s.regs[REG_FREQ0]};
    pacc = s.acc + (s.regs[REG_TXCFG][TX_LP] ?
           {s.regs[REG_PHASE_HI][7:3], 27'h0} :
           {s.regs[REG_PHASE_HI], s.regs[REG_PHASE_LO], 16'h0});
    if (!s.regs[REG_TXCFG][TX_OSC_EN]) n.acc = 32'h0;
    else if (run) n.acc = s.acc + fstep;

    cs = sin6(pacc[31:26] + 6'h10);
    sn = sin6(pacc[31:26]);
    if (md == MOD_NU || md == MOD_NL) sn = -sn;
    ic = $signed(pre[0]) * cs;
    is = $signed(pre[0]) * sn;
    qc = $signed(pre[1]) * cs;
    qs = $signed(pre[1]) * sn;
    if (md == MOD_PU || md == MOD_NU) begin
      ma = sat16(48'((ic - qs) >>> MIX_SHIFT));
      mb = sat16(48'((is + qc) >>> MIX_SHIFT));
    end else if (md == MOD_PL || md == MOD_NL) begin
      ma = sat16(48'((ic + qs) >>> MIX_SHIFT));
      mb = sat16(48'((qc - is) >>> MIX_SHIFT));
    end else begin
      ma = pre[0];
      mb = pre[1];
    end
    if (s.regs[REG_DAC_CFG][DC_GAIN_RED]) begin
      ma = sat16(48'(32'(ma) * GAIN_RED_NUM) >>> GAIN_RED_SHIFT);
      mb = sat16(48'(32'(mb) * GAIN_RED_NUM) >>> GAIN_RED_SHIFT);
    end

    for (int c = 0; c < 2; c++) begin
      if (run) n.dls[c] = push(s.dls[c], (c == 0) ? ma : mb);
      fin[c] = s.regs[REG_TXCFG][TX_SINC] ? fir(n.dls[c], 3) :
               ((c == 0) ? ma : mb);
    end
    nw.a = sat14(fin[0]) ^ 14'h2000;
    nw.b = sat14(fin[1]) ^ 14'h2000;

    // two-entry output buffer, skid stalls the datapath
    if (!s.out_v || out_ready) begin
      if (s.skid_v) begin
        n.outs = s.skid;
        n.skid_v = 1'b0;
        n.out_v = 1'b1;
      end else if (run) begin
        n.outs = nw;
        n.out_v = 1'b1;
      end else begin
        n.out_v = 1'b0;
      end
    end else if (run) begin
      n.skid = nw;
      n.skid_v = 1'b1;
    end
    n.in_rdy = !n.skid_v;
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // clear lines, latches, start on I
      s <= '0;
      s.regs[REG_TXCFG] <= TXCFG_RST;
      s.regs[REG_CLKGEN] <= CLKGEN_RST;
      s.regs[REG_GAIN_A_LO] <= GAIN_LO_RST;
      s.regs[REG_GAIN_A_HI] <= GAIN_HI_RST;
      s.regs[REG_GAIN_B_LO] <= GAIN_LO_RST;
      s.regs[REG_GAIN_B_HI] <= GAIN_HI_RST;
    end else begin
      s <= n;
    end
  end

  // outputs straight from state
  assign reg_rdata = s.rdata;
  assign out_valid = s.out_v;
  assign out_sample = s.outs;
  assign in_ready = s.in_rdy;
  assign rate_marker = s.mark;
  // coarse gain split over two registers
  assign gain_coarse_a = {s.regs[REG_GAIN_A_HI][7:6],
                          s.regs[REG_GAIN_A_LO][7:6]};
  assign gain_coarse_b = {s.regs[REG_GAIN_B_HI][7:6],
                          s.regs[REG_GAIN_B_LO][7:6]};
  assign gain_fine_a = s.regs[REG_GAIN_A_LO][5:0];
  assign gain_fine_b = s.regs[REG_GAIN_B_LO][5:0];
  assign core_clock_phase = s.regs[REG_CLKGEN][CG_PHASE_LSB +: 2];
  assign core_clock_invert = s.regs[REG_CLKGEN][CG_INV];
  assign clock_div_sel = s.regs[REG_CLKGEN][CG_DIV_LSB +: 2];
endmodule

// ===== inc/dac_path_pkg.sv
// constants, coefficient tables and the output sample type for the transmit path
package dac_path_pkg;
  // register offsets
  localparam logic [3:0] REG_COMMON    = 4'h0;
  localparam logic [3:0] REG_TXCFG     = 4'h1;
  localparam logic [3:0] REG_CLKGEN    = 4'h2;
  localparam logic [3:0] REG_FREQ0     = 4'h3;
  localparam logic [3:0] REG_FREQ1     = 4'h4;
  localparam logic [3:0] REG_FREQ2     = 4'h5;
  localparam logic [3:0] REG_FREQ3     = 4'h6;
  localparam logic [3:0] REG_PHASE_LO  = 4'h7;
  localparam logic [3:0] REG_PHASE_HI  = 4'h8;
  localparam logic [3:0] REG_GAIN_A_LO = 4'ha;
  localparam logic [3:0] REG_GAIN_A_HI = 4'hb;
  localparam logic [3:0] REG_GAIN_B_LO = 4'hd;
  localparam logic [3:0] REG_GAIN_B_HI = 4'he;
  localparam logic [3:0] REG_DAC_CFG   = 4'hf;
  // field positions
  localparam int COM_PORT_MODE = 3;
  localparam int COM_CODING    = 2;
  localparam int TX_OSC_EN     = 7;
  localparam int TX_LP         = 6;
  localparam int TX_SINC       = 5;
  localparam int TX_MOD_LSB    = 2;
  localparam int CG_DIV_LSB    = 3;
  localparam int CG_PHASE_LSB  = 1;
  localparam int CG_INV        = 0;
  localparam int DC_GAIN_RED   = 1;
  // reset values and writable masks
  localparam logic [7:0] TXCFG_RST    = 8'h02;
  localparam logic [7:0] CLKGEN_RST   = 8'h08;
  localparam logic [7:0] GAIN_LO_RST  = 8'h40;
  localparam logic [7:0] GAIN_HI_RST  = 8'hc0;
  localparam logic [7:0] CLKGEN_MASK  = 8'hbf;
  localparam logic [7:0] DAC_CFG_MASK = 8'h03;
  // modes
  localparam logic [1:0] INTERP_8X = 2'b11;
  localparam logic [1:0] DIV_2     = 2'b00;
  localparam logic [1:0] DIV_8     = 2'b10;
  localparam logic [2:0] MOD_PU    = 3'b001;
  localparam logic [2:0] MOD_PL    = 3'b010;
  localparam logic [2:0] MOD_NU    = 3'b011;
  localparam logic [2:0] MOD_NL    = 3'b100;
  // filter tables, from the centre outward at odd distance; sinc table at every distance
  localparam int H1_N = 55;
  localparam int H2_N = 23;
  localparam int H3_N = 15;
  localparam int HS_N = 9;
  localparam int H1_C = 32768;
  localparam int H2_C = 4096;
  localparam int H3_C = 8192;
  localparam int HS_C = 401;
  localparam int H1_SIDE [14] = '{20756, -6642, 3671, -2315, 1521, -1003,
    650, -408, 245, -138, 72, -34, 13, -4};
  localparam int H2_SIDE [6] = '{2530, -660, 238, -75, 17, -2};
  localparam int H3_SIDE [4] = '{4964, -1102, 273, -39};
  localparam int HS_SIDE [4] = '{-35, 10, -4, 2};
  localparam int H1_SHIFT = 15;
  localparam int H2_SHIFT = 12;
  localparam int H3_SHIFT = 13;
  localparam int HS_SHIFT = 9;
  localparam int MIX_SHIFT = 13;
  localparam int GAIN_RED_NUM = 181;
  localparam int GAIN_RED_SHIFT = 8;
  // quarter sine, 16 points, amplitude 8191
  localparam int SIN_Q [16] = '{402, 1202, 1990, 2760, 3502, 4211, 4879,
    5501, 6069, 6579, 7026, 7405, 7712, 7946, 8102, 8181};

  typedef struct packed {
    logic [13:0] a;
    logic [13:0] b;
  } out_sample_t;
endpackage

// ===== sim/dac_path_sva.sv
// port assertions for the transmit path
`timescale 1ns/10ps
module dac_path_sva (
  input wire logic                     ref_clk,
  input wire logic                     rst_n,
  input wire logic                     reg_wr_en,
  input wire logic [7:0]               reg_addr,
  input wire logic [7:0]               reg_wdata,
  input wire logic                     out_ready,
  input wire logic                     out_valid,
  input wire dac_path_pkg::out_sample_t out_sample,
  input wire logic                     in_ready,
  input wire logic                     rate_marker,
  input wire logic [3:0]               gain_coarse_a,
  input wire logic [5:0]               gain_fine_a,
  input wire logic [3:0]               gain_coarse_b,
  input wire logic [1:0]               core_clock_phase,
  input wire logic                     core_clock_invert,
  input wire logic [1:0]               clock_div_sel
);
  import dac_path_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_marker_single: assert property (rate_marker |=> !rate_marker)
    else $error("marker wider than one cycle");
  a_space_four: assert property (rate_marker && clock_div_sel == 2'b01 &&
      $past(clock_div_sel) == 2'b01 |=>
      (!rate_marker || clock_div_sel != 2'b01) [*3])
    else $error("words closer than four cycles");
  a_space_eight: assert property (rate_marker && clock_div_sel == DIV_8 &&
      $past(clock_div_sel) == DIV_8 |=>
      (!rate_marker || clock_div_sel != DIV_8) [*7])
    else $error("words closer than eight cycles");
  a_pair_hold: assert property (out_valid && !out_ready |=>
      out_valid && $stable(out_sample))
    else $error("output pair changed before pop");
  a_stall_full: assert property (!in_ready && $past(rst_n) |-> out_valid)
    else $error("input stalled with empty output");
  a_no_take: assert property (!in_ready && $past(rst_n) |=> !rate_marker)
    else $error("word taken while stalled");
  a_clock_fields: assert property (reg_wr_en && reg_addr == 8'h02 |-> ##2
      {clock_div_sel, core_clock_phase, core_clock_invert}
      == $past(reg_wdata[4:0], 2))
    else $error("clock fields differ from written byte");
  a_gain_low_a: assert property (reg_wr_en && reg_addr == 8'h0a |-> ##2
      {gain_coarse_a[1:0], gain_fine_a} == $past(reg_wdata, 2))
    else $error("gain a low byte not applied");
  a_gain_high_b: assert property (reg_wr_en && reg_addr == 8'h0e |-> ##2
      gain_coarse_b[3:2] == $past(reg_wdata[7:6], 2))
    else $error("gain b coarse bits not applied");
endmodule

// ===== sim/iq_source.sv
// baseband source: one word per capture slot, strobe marks I, or Q when swap is set
`timescale 1ns/10ps
module iq_source (
  input  wire logic        ref_clk,
  input  wire logic        rate_marker,
  input  wire logic        interleaved,
  input  wire logic        swap,
  input  wire logic [13:0] word_i,
  input  wire logic [13:0] word_q,
  output logic [13:0]      data_a = 14'h0000,
  output logic [13:0]      data_b = 14'h0000,
  output logic             iq_select_strobe = 1'b0
);
  logic q_next = 1'b0;
  // new word after each marker, strobe rises with I, or with Q when swap is set
  always @(negedge ref_clk) begin
    data_b <= interleaved ? ~data_b : word_q;
    if (rate_marker) begin
      q_next <= ~q_next;
      data_a <= (interleaved && q_next) ? word_q : word_i;
      iq_select_strobe <= interleaved && (q_next == swap);
    end
  end
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the transmit path
`timescale 1ns/10ps
module tb_top;
  import dac_path_pkg::*;
  localparam logic [13:0] MID = 14'h2000;
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              reg_wr_en = 1'b0;
  logic              reg_rd_en = 1'b0;
  logic [7:0]        reg_addr = 8'h00;
  logic [7:0]        reg_wdata = 8'h00;
  logic [7:0]        reg_rdata;
  logic              out_ready = 1'b1;
  logic              out_valid, in_ready, rate_marker;
  out_sample_t       out_sample;
  logic [3:0]        gain_coarse_a, gain_coarse_b;
  logic [5:0]        gain_fine_a, gain_fine_b;
  logic [1:0]        core_clock_phase, clock_div_sel;
  logic              core_clock_invert, iq_select_strobe;
  logic [13:0]       data_a, data_b;
  logic [13:0]       word_i = 14'h0000;
  logic [13:0]       word_q = 14'h0000;
  logic              interleaved = 1'b0;
  logic              swap = 1'b0;
  int                miscompares = 0;
  int                num_checks = 0;
  int                cycles = 0;

  dual_dac_interp_modulator_path dut (.ref_clk, .rst_n, .data_a, .data_b,
    .iq_select_strobe, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
    .reg_rdata, .out_ready, .out_valid, .out_sample, .in_ready,
    .rate_marker, .gain_coarse_a, .gain_fine_a, .gain_coarse_b,
    .gain_fine_b, .core_clock_phase, .core_clock_invert, .clock_div_sel);
  iq_source src (.ref_clk, .rate_marker, .interleaved, .swap, .word_i,
    .word_q, .data_a, .data_b, .iq_select_strobe);

  // clock and hang limit
  // 250 MHz source, under the limits
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
    @(negedge ref_clk);
    chk(16'(reg_rdata), 16'(exp));
  endtask

  // register values after reset, unmapped write refused
  task automatic t_reset_regs();
    logic [7:0] adr [9] = '{8'h01, 8'h02, 8'h09, 8'h0a, 8'h0b, 8'h0d,
      8'h0e, 8'h0f, 8'h10};
    logic [7:0] val [9] = '{8'h02, 8'h08, 8'h00, 8'h40, 8'hc0, 8'h40,
      8'hc0, 8'h00, 8'h00};
    wr(8'h09, 8'hff);
    foreach (adr[k]) rd(adr[k], val[k]);
  endtask

  // clock-generation fields, bypass value and reserved bit
  task automatic t_clock_reg();
    wr(8'h02, 8'h88);
    cyc(2);
    chk(16'({clock_div_sel, core_clock_phase, core_clock_invert}), 16'h08);
    rd(8'h02, 8'h88);
    wr(8'h02, 8'hff);
    cyc(2);
    chk(16'({clock_div_sel, core_clock_phase, core_clock_invert}), 16'h1f);
    rd(8'h02, 8'hbf);
    wr(8'h02, 8'h08);
  endtask

  // coarse and fine gain assembly, fine codes either side of mid-scale
  task automatic t_gain();
    wr(8'h0a, 8'ha0);
    wr(8'h0b, 8'h00);
    wr(8'h0d, 8'h1f);
    wr(8'h0e, 8'hc0);
    cyc(2);
    chk(16'({gain_coarse_a, gain_fine_a}), 16'h0a0);
    chk(16'({gain_coarse_b, gain_fine_b}), 16'h31f);
  endtask

  // word spacing for divider codes 0, 1 and 2
  task automatic t_spacing();
    int n;
    for (int d = 0; d < 3; d++) begin
      wr(8'h02, 8'(d << 3));
      repeat (3) begin
        n = 0;
        do begin
          @(negedge ref_clk);
          n++;
        end while (rate_marker !== 1'b1 && n < 40);
      end
      chk(16'(n), 16'(2 << d));
    end
    wr(8'h02, 8'h08);
  endtask

  // zero maps to mid-scale in both codings
  task automatic t_coding();
    wr(8'h00, 8'h04);
    cyc(300);
    chk(16'(out_sample.a), 16'(MID));
    chk(16'(out_sample.b), 16'(MID));
    wr(8'h00, 8'h00);
    word_i = 14'h2000;
    cyc(300);
    chk(16'(out_sample.a), 16'(MID));
    chk(16'(out_sample.b < MID), 16'h1);
  endtask

  // interleaved steering and resync on strobe
  task automatic t_interleave();
    wr(8'h00, 8'h0c);
    interleaved = 1'b1;
    word_i = 14'h0000;
    word_q = 14'h1000;
    cyc(400);
    chk(16'(out_sample.a), 16'(MID));
    chk(16'(out_sample.b > MID), 16'h1);
    swap = 1'b1;
    cyc(400);
    chk(16'(out_sample.a > MID), 16'h1);
    chk(16'(out_sample.b), 16'(MID));
    swap = 1'b0;
    interleaved = 1'b0;
    wr(8'h00, 8'h04);
  endtask

  // sideband codes at 90 degrees, then gain reduction
  task automatic t_modulate();
    logic [4:0]  above = 5'b01100;
    logic [13:0] full;
    wr(8'h08, 8'h40);
    for (int c = 0; c < 5; c++) begin
      wr(8'h01, 8'h82 | 8'(c << 2));
      cyc(300);
      chk(16'(out_sample.a > MID), 16'(above[c]));
    end
    wr(8'h01, 8'hca);
    cyc(300);
    chk(16'(out_sample.a > MID), 16'h1);
    wr(8'h01, 8'h8a);
    cyc(300);
    full = out_sample.a;
    wr(8'h0f, 8'h02);
    cyc(300);
    chk(16'(out_sample.a < full && out_sample.a > MID), 16'h1);
    wr(8'h0f, 8'h00);
  endtask

  // eight-fold path with inverse sinc, dc 4096 times 347/512
  task automatic t_interp8();
    wr(8'h01, 8'h23);
    cyc(400);
    chk(16'(out_sample.a), 16'(MID));
    chk(16'(out_sample.b), 16'h2ad8);
    wr(8'h01, 8'h02);
  endtask

  // receiver stall fills the buffer, release drains it
  task automatic t_stall();
    out_ready = 1'b0;
    cyc(6);
    chk(16'({in_ready, out_valid}), 16'h1);
    out_ready = 1'b1;
    cyc(6);
    chk(16'(in_ready), 16'h1);
  endtask

  // main sequence
  initial begin
    cyc(12);
    chk(16'({gain_coarse_a, clock_div_sel, out_valid}), 16'h6a);
    rst_n = 1'b1;
    t_reset_regs();
    t_clock_reg();
    t_gain();
    t_spacing();
    t_coding();
    t_interleave();
    t_modulate();
    t_interp8();
    t_stall();
    report_and_stop();
  end
endmodule

bind dual_dac_interp_modulator_path dac_path_sva chk_i (.ref_clk, .rst_n,
  .reg_wr_en, .reg_addr, .reg_wdata, .out_ready, .out_valid, .out_sample,
  .in_ready, .rate_marker, .gain_coarse_a, .gain_fine_a, .gain_coarse_b,
  .core_clock_phase, .core_clock_invert, .clock_div_sel);
